//--- hdl/panel_pkg.sv
// Constants shared by the panel command interpreter and its entry parser.
// Assumes characters arrive as ASCII codes from logic on the same clock.
// Functional notes
// R1: Halt alone stops macro or micro execution, chosen by control bit 12.
// R2: Two decimal digits then halt clear that control register bit.
// R3: Run alone starts macro or micro execution, chosen by control bit 12.
// R4: Two decimal digits then run set that control register bit.
// R5: Half-select alone toggles the upper-half indicator for the display.
// R6: Two digits then half-select replace nibble (first digit 0-5) by second digit.
// R7: Primary display alone shows the register named by its select field.
// R8: Four or eight digits then primary display overwrite that register.
// R9: Secondary display works the same using the secondary select field.
// R10: Codes 101 and 110 do nothing; 111 marks a failed program load.
// R11: After master clear the control code shows 000.
// R12: Every entry ends with a terminator; console also accepts G and at-sign.
// R13: The at-sign terminator also switches control from panel to I/O mode.
// R14: Main memory uses the program counter as address, incremented after display.
// R15: Micromemory address is low register plus high register; low increments after display. The code places the high register byte above the low register byte.
// R16: Control code indicators hold the last code until replaced or cleared.
// R17: Control bit 12 set means commands act on the microprogram.
// R18: Digits buffer until the terminator, then the buffer is discarded.
package panel_pkg;
	localparam logic [2:0] CODE_HALT  = 3'h0;
	localparam logic [2:0] CODE_RUN   = 3'h1;
	localparam logic [2:0] CODE_HALF  = 3'h2;
	localparam logic [2:0] CODE_DISP1 = 3'h3;
	localparam logic [2:0] CODE_DISP0 = 3'h4;
	localparam logic [2:0] CODE_RSV_A = 3'h5;
	localparam logic [2:0] CODE_RSV_B = 3'h6;
	localparam logic [2:0] CODE_FAIL  = 3'h7;

	localparam logic [7:0] CH_0     = 8'h30;
	localparam logic [7:0] CH_9     = 8'h39;
	localparam logic [7:0] CH_A     = 8'h41;
	localparam logic [7:0] CH_F     = 8'h46;
	localparam logic [7:0] CH_G     = 8'h47;
	localparam logic [7:0] CH_H     = 8'h48;
	localparam logic [7:0] CH_N     = 8'h4e;
	localparam logic [7:0] CH_COLON = 8'h3a;
	localparam logic [7:0] CH_AT    = 8'h40;
	localparam logic [7:0] HEX_BIAS = 8'h37;

	localparam int         MODE_BIT   = 12;
	localparam int         DISP0_LSB  = 0;
	localparam int         DISP1_LSB  = 4;
	localparam logic [3:0] NIB_MAX    = 4'h5;
	localparam logic [3:0] DEC_MAX    = 4'h9;
	localparam logic [7:0] DEC_TEN    = 8'h0a;
	localparam logic [7:0] BIT_LIMIT  = 8'h20;
	localparam logic [3:0] NDIG_NONE  = 4'h0;
	localparam logic [3:0] NDIG_TWO   = 4'h2;
	localparam logic [3:0] NDIG_HALF  = 4'h4;
	localparam logic [3:0] NDIG_FULL  = 4'h8;
	localparam logic [3:0] NDIG_OVER  = 4'h9;

	localparam logic [3:0] REG_FCR    = 4'h0;
	localparam logic [3:0] REG_PC     = 4'h1;
	localparam logic [3:0] REG_ULOW   = 4'h2;
	localparam logic [3:0] REG_UHIGH  = 4'h3;
	localparam logic [3:0] SEL_MAIN   = 4'he;
	localparam logic [3:0] SEL_MICRO  = 4'hf;
	localparam int         NUM_REGS   = 16;
	localparam logic [31:0] PC_STEP   = 32'h0000_0001;
	localparam logic [7:0]  ULOW_STEP = 8'h01;
endpackage

//--- hdl/entry_if.sv
// Carrier for decoded operator entries between parser and executor.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface entry_if;
	logic        code_vld;
	logic [2:0]  code;
	logic        cmd_vld;
	logic [2:0]  cmd;
	logic [3:0]  ndig;
	logic [31:0] digits;
	logic        to_io;
	modport parser (output code_vld, code, cmd_vld, cmd, ndig, digits, to_io);
	modport exec   (input code_vld, code, cmd_vld, cmd, ndig, digits, to_io);
endinterface

//--- hdl/entry_parser.sv
// Entry parser: collects hex digits, a control character and a terminator.
// Assumes characters come one per i_char_valid pulse from same-clock logic.
`timescale 1ns/1ps
module entry_parser (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_char_valid,
	input  wire logic [7:0] i_char,
	input  wire logic       i_remote,
	entry_if.parser         ent
);
	import panel_pkg::*;

	typedef enum logic {ST_DIGITS, ST_CTRL} pstate_t;

	pstate_t     state_r;
	logic [31:0] buf_r;
	logic [3:0]  ndig_r;
	logic [2:0]  ctrl_r;
	logic        is_dec;
	logic        is_hex;
	logic        is_ctrl;
	logic        is_term;
	logic [3:0]  nib;

	// ==========================================================
	// Character classes
	always_comb begin
		is_dec  = (i_char >= CH_0) && (i_char <= CH_9);
		is_hex  = is_dec || ((i_char >= CH_A) && (i_char <= CH_F));
		is_ctrl = (i_char >= CH_H) && (i_char <= CH_N);
		is_term = (i_char == CH_COLON) ||
			(i_remote && ((i_char == CH_G) || (i_char == CH_AT))); // R12
		nib     = is_dec ? i_char[3:0] : 4'((i_char - HEX_BIAS) & 8'h0f);
	end

	// ==========================================================
	// Entry sequencing
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_r    <= ST_DIGITS;
			buf_r      <= '0;
			ndig_r     <= NDIG_NONE;
			ctrl_r     <= CODE_HALT;
			ent.code_vld <= 1'b0;
			ent.code   <= CODE_HALT;
			ent.cmd_vld  <= 1'b0;
			ent.cmd    <= CODE_HALT;
			ent.ndig   <= NDIG_NONE;
			ent.digits <= '0;
			ent.to_io  <= 1'b0;
		end else begin
			ent.code_vld <= 1'b0;
			ent.cmd_vld  <= 1'b0;
			if (i_char_valid) begin
				case (state_r)
					ST_DIGITS: begin
						if (is_hex) begin
							buf_r  <= {buf_r[27:0], nib}; // R18
							ndig_r <= (ndig_r == NDIG_OVER) ? NDIG_OVER : ndig_r + 4'h1;
						end else if (is_ctrl) begin
							ctrl_r       <= 3'(i_char - CH_H);
							ent.code_vld <= 1'b1;
							ent.code     <= 3'(i_char - CH_H);
							state_r      <= ST_CTRL;
						end else begin
							buf_r  <= '0;
							ndig_r <= NDIG_NONE;
						end
					end
					ST_CTRL: begin
						if (is_term) begin
							ent.cmd_vld <= 1'b1; // R12
							ent.cmd     <= ctrl_r;
							ent.ndig    <= ndig_r;
							ent.digits  <= buf_r;
							ent.to_io   <= (i_char == CH_AT); // R13
						end
						buf_r   <= '0; // R18
						ndig_r  <= NDIG_NONE;
						state_r <= ST_DIGITS;
					end
					default: state_r <= ST_DIGITS;
				endcase
			end
		end
	end
endmodule // entry_parser

//--- hdl/panel_interp.sv
// Panel command interpreter: executes operator entries on the control
// register, a 16-entry register file, and main or micro memory.
// Assumes a memory port that answers each request with a one-cycle ack.
`timescale 1ns/1ps
module panel_interp (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_char_valid,
	input  wire logic [7:0]  i_char,
	input  wire logic        i_remote,
	input  wire logic        i_load_fail,
	input  wire logic        i_io_release,
	input  wire logic        i_mem_ack,
	input  wire logic [31:0] i_mem_rdata,
	output logic [2:0]       o_ctrl_code,
	output logic             o_upper,
	output logic [15:0]      o_display,
	output logic [31:0]      o_fcr,
	output logic             o_io_mode,
	output logic             o_halt_macro,
	output logic             o_halt_micro,
	output logic             o_run_macro,
	output logic             o_run_micro,
	output logic             o_mem_req,
	output logic             o_mem_we,
	output logic             o_mem_micro,
	output logic [15:0]      o_mem_addr,
	output logic [31:0]      o_mem_wdata
);
	import panel_pkg::*;

	typedef enum logic {EX_IDLE, EX_MEM} xstate_t;

	entry_if     ent ();
	xstate_t     state_r;
	logic [31:0] regs_r [NUM_REGS];
	logic [31:0] disp_r;
	logic        upper_r;
	logic        mem_rd_r;
	logic        mem_micro_r;
	logic [3:0]  sel;
	logic [3:0]  d_hi;
	logic [3:0]  d_lo;
	logic [7:0]  bit_idx;
	logic        bit_ok;
	logic        go;
	logic        is_disp;
	logic        wr_ok;
	logic [31:0] wr_val;

	entry_parser u_parser (
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_char_valid (i_char_valid),
		.i_char       (i_char),
		.i_remote     (i_remote),
		.ent          (ent)
	);

	// ==========================================================
	// Entry decode
	always_comb begin
		d_hi    = ent.digits[7:4];
		d_lo    = ent.digits[3:0];
		bit_idx = {4'h0, d_hi} * DEC_TEN + {4'h0, d_lo};
		bit_ok  = (d_hi <= DEC_MAX) && (d_lo <= DEC_MAX) && (bit_idx < BIT_LIMIT);
		go      = ent.cmd_vld && (state_r == EX_IDLE);
		is_disp = (ent.cmd == CODE_DISP1) || (ent.cmd == CODE_DISP0);
		sel     = (ent.cmd == CODE_DISP1) ? regs_r[REG_FCR][DISP1_LSB +: 4]
			: regs_r[REG_FCR][DISP0_LSB +: 4]; // R9
		wr_ok   = (ent.ndig == NDIG_HALF) || (ent.ndig == NDIG_FULL); // R8
		wr_val  = ent.digits;
		if (ent.ndig == NDIG_HALF && sel < SEL_MAIN) begin
			wr_val = upper_r ? {ent.digits[15:0], regs_r[sel][15:0]}
				: {regs_r[sel][31:16], ent.digits[15:0]};
		end
	end

	// ==========================================================
	// Register file and control register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_r[i] <= '0;
			end
		end else if (go) begin
			case (ent.cmd)
				CODE_HALT: if (ent.ndig == NDIG_TWO && bit_ok)
					regs_r[REG_FCR][bit_idx[4:0]] <= 1'b0; // R2
				CODE_RUN: if (ent.ndig == NDIG_TWO && bit_ok)
					regs_r[REG_FCR][bit_idx[4:0]] <= 1'b1; // R4
				CODE_HALF: if (ent.ndig == NDIG_TWO && d_hi <= NIB_MAX)
					regs_r[REG_FCR][{d_hi[2:0], 2'b00} +: 4] <= d_lo; // R6
				CODE_DISP1, CODE_DISP0: begin
					if (ent.ndig == NDIG_NONE && sel == SEL_MAIN)
						regs_r[REG_PC] <= regs_r[REG_PC] + PC_STEP; // R14
					else if (ent.ndig == NDIG_NONE && sel == SEL_MICRO)
						regs_r[REG_ULOW][7:0] <= regs_r[REG_ULOW][7:0] + ULOW_STEP; // R15
					else if (wr_ok && sel < SEL_MAIN)
						regs_r[sel] <= wr_val; // R8
				end
				default: ; // R10
			endcase
		end
	end

	// ==========================================================
	// Memory access sequencing
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_r     <= EX_IDLE;
			o_mem_req   <= 1'b0;
			o_mem_we    <= 1'b0;
			o_mem_micro <= 1'b0;
			o_mem_addr  <= '0;
			o_mem_wdata <= '0;
			mem_rd_r    <= 1'b0;
			mem_micro_r <= 1'b0;
		end else begin
			case (state_r)
				EX_IDLE: begin
					if (go && is_disp && (sel == SEL_MAIN || sel == SEL_MICRO) &&
						(ent.ndig == NDIG_NONE || wr_ok)) begin
						state_r     <= EX_MEM;
						o_mem_req   <= 1'b1;
						o_mem_we    <= wr_ok;
						o_mem_micro <= (sel == SEL_MICRO);
						mem_micro_r <= (sel == SEL_MICRO);
						mem_rd_r    <= !wr_ok;
						o_mem_wdata <= ent.digits;
						o_mem_addr  <= (sel == SEL_MAIN) ? regs_r[REG_PC][15:0] // R14
							: {regs_r[REG_UHIGH][7:0], regs_r[REG_ULOW][7:0]}; // R15
					end
				end
				EX_MEM: begin
					if (i_mem_ack) begin
						o_mem_req <= 1'b0;
						o_mem_we  <= 1'b0;
						state_r   <= EX_IDLE;
					end
				end
				default: state_r <= EX_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Display data and upper-half indicator
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			disp_r <= '0;
		end else if (state_r == EX_MEM && i_mem_ack && mem_rd_r) begin
			disp_r <= i_mem_rdata;
		end else if (go && is_disp && sel < SEL_MAIN) begin
			disp_r <= wr_ok ? wr_val : regs_r[sel]; // R7
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			upper_r <= 1'b0;
		end else if (go && ent.cmd == CODE_HALF && ent.ndig == NDIG_NONE) begin
			upper_r <= !upper_r; // R5
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_display <= '0;
			o_upper   <= 1'b0;
			o_fcr     <= '0;
		end else begin
			o_display <= upper_r ? disp_r[31:16] : disp_r[15:0]; // R5
			o_upper   <= upper_r;
			o_fcr     <= regs_r[REG_FCR];
		end
	end

	// ==========================================================
	// Control code indicators
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ctrl_code <= CODE_HALT; // R11
		end else if (i_load_fail) begin
			o_ctrl_code <= CODE_FAIL; // R10
		end else if (ent.code_vld) begin
			o_ctrl_code <= ent.code; // R16
		end
	end

	// ==========================================================
	// Execution control and mode
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_halt_macro <= 1'b0;
			o_halt_micro <= 1'b0;
			o_run_macro  <= 1'b0;
			o_run_micro  <= 1'b0;
		end else begin
			o_halt_macro <= go && ent.cmd == CODE_HALT && ent.ndig == NDIG_NONE &&
				!regs_r[REG_FCR][MODE_BIT]; // R1
			o_halt_micro <= go && ent.cmd == CODE_HALT && ent.ndig == NDIG_NONE &&
				regs_r[REG_FCR][MODE_BIT]; // R17
			o_run_macro  <= go && ent.cmd == CODE_RUN && ent.ndig == NDIG_NONE &&
				!regs_r[REG_FCR][MODE_BIT]; // R3
			o_run_micro  <= go && ent.cmd == CODE_RUN && ent.ndig == NDIG_NONE &&
				regs_r[REG_FCR][MODE_BIT]; // R17
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_io_mode <= 1'b0;
		end else if (ent.cmd_vld && ent.to_io) begin
			o_io_mode <= 1'b1; // R13
		end else if (i_io_release) begin
			o_io_mode <= 1'b0;
		end
	end
endmodule // panel_interp

//--- verif/panel_interp_asserts.sv
// Port-level assertions for panel_interp.
// Assumes a bind onto the top module; one clock, synchronous reset.
`timescale 1ns/1ps
module panel_interp_asserts import panel_pkg::*; (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_char_valid,
	input wire logic [7:0]  i_char,
	input wire logic        i_remote,
	input wire logic        i_load_fail,
	input wire logic        i_mem_ack,
	input wire logic [2:0]  o_ctrl_code,
	input wire logic        o_upper,
	input wire logic [31:0] o_fcr,
	input wire logic        o_io_mode,
	input wire logic        o_halt_macro,
	input wire logic        o_halt_micro,
	input wire logic        o_run_macro,
	input wire logic        o_run_micro,
	input wire logic        o_mem_req,
	input wire logic        o_mem_we,
	input wire logic [15:0] o_mem_addr
);
	// ==========
	// Terminator history
	logic term;
	logic t1_r, t2_r, t3_r;
	assign term = i_char_valid && (i_char == CH_COLON ||
		(i_remote && (i_char == CH_G || i_char == CH_AT)));
	always_ff @(posedge i_clk) begin
		t1_r <= term;
		t2_r <= t1_r;
		t3_r <= t2_r;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// ==========
	// Properties
	property p_clr; $past(i_rst) |-> o_ctrl_code == CODE_HALT; endproperty
	a_clr: assert property (p_clr) else $error("code not cleared");
	property p_code; (i_char_valid && i_char >= CH_H && i_char <= CH_N && !i_load_fail)
		##1 !i_load_fail |=> ({5'h0, o_ctrl_code} + CH_H) == $past(i_char, 2); endproperty
	a_code: assert property (p_code) else $error("wrong control code");
	property p_hold; o_ctrl_code != $past(o_ctrl_code) |-> o_ctrl_code == CODE_FAIL ||
		($past(i_char_valid, 2) && $past(i_char, 2) >= CH_H && $past(i_char, 2) <= CH_N);
	endproperty
	a_hold: assert property (p_hold) else $error("code changed alone");
	property p_mic; (o_run_micro || o_halt_micro) |-> o_fcr[MODE_BIT]; endproperty
	a_mic: assert property (p_mic) else $error("micro pulse in macro mode");
	property p_mac; (o_run_macro || o_halt_macro) |-> !o_fcr[MODE_BIT]; endproperty
	a_mac: assert property (p_mac) else $error("macro pulse in micro mode");
	property p_pulse; (o_run_macro || o_run_micro || o_halt_macro || o_halt_micro) |-> t2_r;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse without entry");
	property p_io; $rose(o_io_mode) |-> t2_r && $past(i_char, 2) == CH_AT; endproperty
	a_io: assert property (p_io) else $error("io mode without at-sign");
	property p_upper; $changed(o_upper) |-> t3_r; endproperty
	a_upper: assert property (p_upper) else $error("upper changed alone");
	property p_fcr; $changed(o_fcr) |-> t3_r; endproperty
	a_fcr: assert property (p_fcr) else $error("control reg changed alone");
	property p_mhold; o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) &&
		$stable(o_mem_we); endproperty
	a_mhold: assert property (p_mhold) else $error("memory request dropped");
	c_mic: cover property (o_run_micro);
	c_mem: cover property (o_mem_req && i_mem_ack);
	c_fail: cover property (o_ctrl_code == CODE_FAIL);
endmodule // panel_interp_asserts

//--- verif/mem_model.sv
// Memory responder: acks each request after a random wait.
// Assumes the requester holds its request until the ack edge.
`timescale 1ns/1ps
module mem_model (
	input wire logic         i_clk,
	input wire logic         i_rst,
	input wire logic         i_req,
	input wire logic [15:0]  i_addr,
	output logic             o_ack,
	output logic [31:0]      o_rdata
);
	// ==========
	// Responder
	logic [1:0] w_r;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ack <= 1'b0;
			o_rdata <= 32'h0f0f_0f0f;
		end else if (o_ack || !i_req) begin
			o_ack <= 1'b0;
			w_r <= 2'($urandom);
			o_rdata <= ~o_rdata;
		end else if (w_r == 2'h0) begin
			o_ack <= 1'b1;
			o_rdata <= {i_addr, ~i_addr};
		end else begin
			w_r <= w_r - 2'h1;
			o_rdata <= ~o_rdata;
		end
	end
endmodule // mem_model

//--- verif/tb_top.sv
// Self-checking bench for panel_interp with a memory responder.
// Assumes design, checker and memory model compiled first.
`timescale 1ns/1ps
module tb_top;
	import panel_pkg::*;
	logic        i_clk, i_rst, i_char_valid, i_remote, i_load_fail, i_io_release;
	logic [7:0]  i_char;
	logic        ack, upr, iom, hma, hmi, rma, rmi, req, we, mic, lmic, lwe;
	logic [31:0] rdat, fcr, wdat, lwd;
	logic [2:0]  code;
	logic [15:0] disp, addr, la;
	logic [3:0]  lp;
	int          bad_count, cmp_count, np, nack, cyc, b;
	panel_interp dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_char_valid(i_char_valid),
		.i_char(i_char), .i_remote(i_remote), .i_load_fail(i_load_fail),
		.i_io_release(i_io_release), .i_mem_ack(ack), .i_mem_rdata(rdat),
		.o_ctrl_code(code), .o_upper(upr), .o_display(disp), .o_fcr(fcr),
		.o_io_mode(iom), .o_halt_macro(hma), .o_halt_micro(hmi), .o_run_macro(rma),
		.o_run_micro(rmi), .o_mem_req(req), .o_mem_we(we), .o_mem_micro(mic),
		.o_mem_addr(addr), .o_mem_wdata(wdat));
	mem_model mem_u (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_addr(addr),
		.o_ack(ack), .o_rdata(rdat));
	// ==========
	// Tasks
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic send(string s);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge i_clk);
			#1 i_char_valid = 1'b1;
			i_char = s[i];
		end
		@(posedge i_clk);
		#1 i_char_valid = 1'b0;
		repeat (4) @(posedge i_clk);
		#1;
	endtask
	task automatic mem(string s);
		int n;
		n = nack;
		send(s);
		for (int k = 0; k < 20 && nack == n; k++) @(posedge i_clk);
		repeat (3) @(posedge i_clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		@(posedge i_clk);
		#1 s = 1'b1;
		@(posedge i_clk);
		#1 s = 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
	endtask
	task automatic rst();
		i_rst = 1'b1;
		repeat (3) @(posedge i_clk);
		#1 i_rst = 1'b0;
		chk(code, CODE_HALT);
		chk(fcr, 0);
	endtask
	// ==========
	// Monitor and stimulus
	always @(posedge i_clk) begin
		cyc++;
		if (hma || hmi || rma || rmi) begin
			np++;
			lp = {hma, hmi, rma, rmi};
		end
		if (req && ack) begin
			nack++;
			la = addr;
			lmic = mic;
			lwe = we;
			lwd = wdat;
		end
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	initial begin
		{i_rst, i_char_valid, i_remote, i_load_fail, i_io_release} = 5'h10;
		i_char = 8'h00;
		void'($urandom(56));
		rst();
		for (int k = 0; k < 4; k++) begin
			b = $urandom % 32;
			send($sformatf("%02dI:", b));
			chk(fcr[b], 1);
			chk(code, CODE_RUN);
			send($sformatf("%02dH:", b));
			chk(fcr, 0);
		end
		send("I:");
		chk(lp, 4'h2);
		send("H:");
		chk(lp, 4'h8);
		send("12I:I:");
		chk(lp, 4'h1);
		send("H:12H:05:I:");
		chk(lp, 4'h2);
		chk(np, 5);
		chk(fcr, 0);
		$display("test run_halt done");
		send("J:2AJ:");
		chk(upr, 1);
		chk(fcr, 32'h0a00);
		send("20J:J:11J:00000010K:");
		chk(disp, 16'h0010);
		send("K:");
		chk(disp, 16'h0010);
		send("J:ABCDK:");
		chk(disp, 16'habcd);
		send("J:");
		chk(disp, 16'h0010);
		send("1EJ:");
		mem("K:");
		chk(la, 16'h0010);
		chk(disp, 16'hffef);
		chk({lwe, lmic}, 2'b00);
		mem("K:");
		chk(la, 16'h0011);
		mem("CAFE1234K:");
		chk(lwd, 32'hcafe1234);
		chk({lwe, lmic}, 2'b10);
		chk(la, 16'h0012);
		send("0EJ:");
		mem("L:");
		chk(la, 16'h0012);
		send("12J:000000ABK:13J:000000CDK:1FJ:");
		mem("K:");
		chk({lmic, la}, 17'h1cdab);
		mem("K:");
		chk(la, 16'hcdac);
		$display("test memory done");
		i_remote = 1'b1;
		send("JG");
		chk(upr, 1);
		send("J@");
		chk({upr, iom}, 2'b01);
		pulse(i_io_release);
		chk(iom, 0);
		i_remote = 1'b0;
		send("JG");
		chk(upr, 0);
		send("M:");
		chk(code, CODE_RSV_A);
		send("N:");
		chk(code, CODE_RSV_B);
		pulse(i_load_fail);
		repeat (10) @(posedge i_clk);
		#1;
		chk(code, CODE_FAIL);
		rst();
		chk(upr, 0);
		$display("test misc done");
		finish_test();
	end
endmodule // tb_top
bind panel_interp panel_interp_asserts chk_u (.i_clk(i_clk), .i_rst(i_rst),
	.i_char_valid(i_char_valid), .i_char(i_char), .i_remote(i_remote),
	.i_load_fail(i_load_fail),
	.i_mem_ack(i_mem_ack), .o_ctrl_code(o_ctrl_code), .o_upper(o_upper), .o_fcr(o_fcr),
	.o_io_mode(o_io_mode), .o_halt_macro(o_halt_macro), .o_halt_micro(o_halt_micro),
	.o_run_macro(o_run_macro), .o_run_micro(o_run_micro), .o_mem_req(o_mem_req),
	.o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr));
